// >>> rtl/pmv_pkg.sv
// Constants and types shared by both ends of the power-mode controller
// ==========================================================
// Summary of operation
// [RULE_01] Run and both waits use main regulator
// [RULE_02] Halt and low-power modes use low-power regulator; active-halt per [RULE_21]
// [RULE_03] Enabled detector interrupt wakes halts only
// [RULE_04] Bit 6 shows supply below threshold
// [RULE_05] Bit 5 set per event, write-one clears
// [RULE_06] Bit 4 gates flag onto interrupt request
// [RULE_07] Bits 3:1 pick level, 111 external pin
// [RULE_08] Bit 0 switches the detector on
// [RULE_09] Reference bit 0 shows reference stable
// [RULE_10] Software waits for reference before changing bits
// [RULE_11] Reserved bits zero, both registers reset 0x00
// [RULE_12] Every reset starts in Run
// [RULE_13] Wait stops CPU; interrupts, events exit
// [RULE_14] Low-power run entered/left by software only
// [RULE_15] Event-wait in low-power run, event returns
// [RULE_16] Active-halt wakes on external, RTC interrupt
// [RULE_17] Halt wakes on external; fast wake 6 us
// [RULE_18] Halt ignored while peripheral interrupt pending
// [RULE_19] Detector event on crossings both directions
// [RULE_20] Low-power bit stops reference; fast skips wait
// [RULE_21] Regulator output; clock controller picks halt mode
`default_nettype none
package pmv_pkg;
    // ==========================================================
    // Device register indices and fields
    localparam logic [7:0] PMV_DET_IDX = 8'h00;
    localparam logic [7:0] PMV_REF_IDX = 8'h01;
    localparam logic [7:0] PMV_DET_RST = 8'h00;
    localparam logic [7:0] PMV_REF_RST = 8'h00;
    localparam int PMV_B_OUT = 6;
    localparam int PMV_B_FLAG = 5;
    localparam int PMV_B_IEN = 4;
    localparam int PMV_B_LVL = 1;
    localparam int PMV_B_DEN = 0;
    localparam int PMV_B_FWU = 2;
    localparam int PMV_B_ULP = 1;
    localparam int PMV_B_RDY = 0;
    localparam logic [2:0] PMV_LVL_EXT = 3'h7;
    // ==========================================================
    // Host register byte addresses
    localparam logic [7:0] PMV_H_CMD = 8'h00;
    localparam logic [7:0] PMV_H_CFG = 8'h04;
    localparam logic [7:0] PMV_H_STAT = 8'h08;
    localparam logic [7:0] PMV_H_DEV = 8'h10;
    localparam int PMV_C_WFI = 0;
    localparam int PMV_C_WFE = 1;
    localparam int PMV_C_HALT = 2;
    localparam int PMV_C_LPIN = 3;
    localparam int PMV_C_LPOUT = 4;
    localparam int PMV_S_IGN = 4;
    // ==========================================================
    // Timing
    localparam int PMV_CLK_NS = 40;
    localparam int PMV_FAST_WAKE_NS = 6000;
    localparam int PMV_FAST_CYC =
        (PMV_FAST_WAKE_NS + PMV_CLK_NS - 1) / PMV_CLK_NS;
    localparam int PMV_REF_START_US = 3000;
    localparam int PMV_REF_CYC = (PMV_REF_START_US * 1000) / PMV_CLK_NS;
    // ==========================================================
    // Power modes
    typedef enum logic [2:0] {
        PMV_RUN = 3'h0,
        PMV_WAIT_WFI = 3'h1,
        PMV_WAIT_WFE = 3'h2,
        PMV_LP_RUN = 3'h3,
        PMV_LP_WAIT = 3'h4,
        PMV_ACT_HALT = 3'h5,
        PMV_HALT = 3'h6,
        PMV_WAKE = 3'h7
    } pmv_mode_type;
endpackage
`default_nettype wire

// >>> rtl/pmv_if.sv
// Link between the power unit and the CPU core / clock controller
`timescale 1ns/1ps
`default_nettype none
interface pmv_if;
    import pmv_pkg::*;
    // ==========================================================
    // Register access into the power unit
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    // ==========================================================
    // Instructions and wake sources from the core side
    logic wfi_req;
    logic wfe_req;
    logic halt_req;
    logic lprun_enter;
    logic lprun_exit;
    logic any_irq;
    logic wake_event;
    logic ext_irq;
    logic rtc_irq;
    logic periph_pending;
    logic rtc_clk_on;
    logic ah_ulp_sel;
    // ==========================================================
    // Mode and clock gating back to the core side
    pmv_mode_type mode;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_en;
    logic main_reg;
    logic det_irq;
    logic halt_ignored;

    modport dev (
        input reg_addr, reg_wr, reg_rd, reg_wdata,
        output reg_rdata,
        input wfi_req, wfe_req, halt_req, lprun_enter, lprun_exit,
        input any_irq, wake_event, ext_irq, rtc_irq, periph_pending,
        input rtc_clk_on, ah_ulp_sel,
        output mode, cpu_clk_en, periph_clk_en, osc_en, main_reg,
        output det_irq, halt_ignored
    );
    modport host (
        output reg_addr, reg_wr, reg_rd, reg_wdata,
        input reg_rdata,
        output wfi_req, wfe_req, halt_req, lprun_enter, lprun_exit,
        output any_irq, wake_event, ext_irq, rtc_irq, periph_pending,
        output rtc_clk_on, ah_ulp_sel,
        input mode, cpu_clk_en, periph_clk_en, osc_en, main_reg,
        input det_irq, halt_ignored
    );
endinterface
`default_nettype wire

// >>> rtl/pmv_dev.sv
// Power unit: supply detector, reference control, power-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module pmv_dev #(
    parameter int unsigned REF_START_CYCLES = pmv_pkg::PMV_REF_CYC,
    parameter int unsigned FAST_WAKE_CYCLES = pmv_pkg::PMV_FAST_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    pmv_if.dev link,
    input wire logic supply_below_raw,
    input wire logic ext_below_raw,
    output logic det_on,
    output logic [2:0] det_level,
    output logic ref_on,
    output logic main_reg
);
    import pmv_pkg::*;

    // ==========================================================
    // Elaboration checks
    if (REF_START_CYCLES < 1 || REF_START_CYCLES > 32'h7fff_ffff) begin
        $error("REF_START_CYCLES out of range");
    end
    if (FAST_WAKE_CYCLES < 1 || FAST_WAKE_CYCLES > 32'h7fff_ffff) begin
        $error("FAST_WAKE_CYCLES out of range");
    end

    // ==========================================================
    // State
    pmv_mode_type state_q, state_d;
    logic sup_s1_q, sup_s2_q, ext_s1_q, ext_s2_q;
    logic det_en_q, irq_en_q, flag_q, det_out_q;
    logic [2:0] lvl_q;
    logic fwu_q, ulp_q, ref_rdy_q, ref_on_q;
    logic [31:0] ref_cnt_q, wake_cnt_q;
    logic [7:0] rdata_q;
    logic cpu_q, per_q, osc_q, main_q, irq_q, ign_q;
    logic det_new, det_evt, wr_det, wr_ref, ref_want, wake_done;

    // Both comparator outputs are asynchronous to mclk
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sup_s1_q <= 1'b0;
            sup_s2_q <= 1'b0;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
        end else begin
            sup_s1_q <= supply_below_raw;
            sup_s2_q <= sup_s1_q;
            ext_s1_q <= ext_below_raw;
            ext_s2_q <= ext_s1_q;
        end
    end

    // ==========================================================
    // Supply detector
    // Code 111 swaps the internal divider for the external pin
    assign det_new = det_en_q &&
        ((lvl_q == PMV_LVL_EXT) ? ext_s2_q : sup_s2_q); // see [RULE_07]
    // Any change of the output while on is an event, up or down
    assign det_evt = det_en_q && (det_new != det_out_q); // see [RULE_19]
    assign wr_det = link.reg_wr && (link.reg_addr == PMV_DET_IDX);
    assign wr_ref = link.reg_wr && (link.reg_addr == PMV_REF_IDX);

    // Output status follows the comparator, never software
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            det_out_q <= 1'b0;
        end else begin
            det_out_q <= det_new; // see [RULE_04]
        end
    end

    // Software fields of the detector register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_en_q <= PMV_DET_RST[PMV_B_IEN]; // see [RULE_11]
            lvl_q <= PMV_DET_RST[PMV_B_LVL +: 3];
            det_en_q <= PMV_DET_RST[PMV_B_DEN];
        end else if (wr_det) begin
            irq_en_q <= link.reg_wdata[PMV_B_IEN]; // see [RULE_06]
            lvl_q <= link.reg_wdata[PMV_B_LVL +: 3]; // see [RULE_07]
            det_en_q <= link.reg_wdata[PMV_B_DEN]; // see [RULE_08]
        end
    end

    // Event flag: a new event beats a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (det_evt) begin
            flag_q <= 1'b1; // see [RULE_05]
        end else if (wr_det && link.reg_wdata[PMV_B_FLAG]) begin
            flag_q <= 1'b0; // see [RULE_05]
        end
    end

    // ==========================================================
    // Internal reference
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fwu_q <= PMV_REF_RST[PMV_B_FWU];
            ulp_q <= PMV_REF_RST[PMV_B_ULP];
        end else if (wr_ref) begin
            fwu_q <= link.reg_wdata[PMV_B_FWU]; // see [RULE_20]
            ulp_q <= link.reg_wdata[PMV_B_ULP]; // see [RULE_20]
        end
    end

    // Low-power setting drops the reference only while halted
    assign ref_want = !(ulp_q &&
        (state_q == PMV_HALT || state_q == PMV_ACT_HALT)); // see [RULE_20]

    // Settling counter; ready stays low until the full startup time
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ref_on_q <= 1'b0;
            ref_cnt_q <= 32'h0000_0000;
            ref_rdy_q <= 1'b0;
        end else if (!ref_want) begin
            ref_on_q <= 1'b0;
            ref_cnt_q <= 32'h0000_0000;
            ref_rdy_q <= 1'b0; // see [RULE_09]
        end else begin
            ref_on_q <= 1'b1;
            if (ref_cnt_q < REF_START_CYCLES - 1) begin
                ref_cnt_q <= ref_cnt_q + 32'h0000_0001;
            end else begin
                ref_rdy_q <= 1'b1; // see [RULE_09]
            end
        end
    end

    // ==========================================================
    // Register read port, data one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (link.reg_rd) begin
            case (link.reg_addr)
                PMV_DET_IDX: rdata_q <= {1'b0, det_out_q, flag_q,
                    irq_en_q, lvl_q, det_en_q}; // see [RULE_11]
                PMV_REF_IDX: rdata_q <= {5'h00, fwu_q, ulp_q,
                    ref_rdy_q}; // see [RULE_09]
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Power-mode sequencer
    // Halt wake waits for the reference only in ulp without fast wake
    assign wake_done = (ulp_q && !fwu_q) ? ref_rdy_q :
        (wake_cnt_q >= FAST_WAKE_CYCLES - 1); // see [RULE_17]

    always_comb begin
        state_d = state_q;
        case (state_q)
            PMV_RUN: begin
                if (link.halt_req && !link.periph_pending) begin
                    // Real-time clock running selects active-halt
                    state_d = link.rtc_clk_on ? PMV_ACT_HALT
                        : PMV_HALT; // see [RULE_18]
                end else if (link.wfi_req) begin
                    state_d = PMV_WAIT_WFI; // see [RULE_13]
                end else if (link.wfe_req) begin
                    state_d = PMV_WAIT_WFE; // see [RULE_13]
                end else if (link.lprun_enter) begin
                    state_d = PMV_LP_RUN; // see [RULE_14]
                end
            end
            // Detector interrupt is not among the wait exits
            PMV_WAIT_WFI: begin
                if (link.any_irq) begin
                    state_d = PMV_RUN; // see [RULE_13]
                end
            end
            PMV_WAIT_WFE: begin
                if (link.any_irq || link.wake_event) begin
                    state_d = PMV_RUN; // see [RULE_13]
                end
            end
            // Interrupts are deliberately not looked at here
            PMV_LP_RUN: begin
                if (link.lprun_exit) begin
                    state_d = PMV_RUN; // see [RULE_14]
                end else if (link.wfe_req) begin
                    state_d = PMV_LP_WAIT; // see [RULE_15]
                end
            end
            PMV_LP_WAIT: begin
                if (link.wake_event) begin
                    state_d = PMV_LP_RUN; // see [RULE_15]
                end
            end
            PMV_ACT_HALT: begin
                if (link.ext_irq || link.rtc_irq || irq_q) begin
                    state_d = PMV_WAKE; // see [RULE_16] [RULE_03]
                end
            end
            PMV_HALT: begin
                if (link.ext_irq || irq_q) begin
                    state_d = PMV_WAKE; // see [RULE_17] [RULE_03]
                end
            end
            PMV_WAKE: begin
                if (wake_done) begin
                    state_d = PMV_RUN;
                end
            end
            default: state_d = PMV_RUN;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= PMV_RUN; // see [RULE_12]
        end else begin
            state_q <= state_d;
        end
    end

    // Wake timer restarts on every halt exit
    always_ff @(posedge mclk) begin
        if (!rst_n || state_q != PMV_WAKE) begin
            wake_cnt_q <= 32'h0000_0000;
        end else if (!wake_done) begin
            wake_cnt_q <= wake_cnt_q + 32'h0000_0001;
        end
    end

    // Gating and regulator outputs registered from the next mode
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cpu_q <= 1'b1;
            per_q <= 1'b1;
            osc_q <= 1'b1;
            main_q <= 1'b1; // see [RULE_12]
        end else begin
            cpu_q <= (state_d == PMV_RUN || state_d == PMV_LP_RUN);
            per_q <= (state_d != PMV_HALT && state_d != PMV_ACT_HALT);
            osc_q <= (state_d != PMV_HALT); // see [RULE_17]
            case (state_d)
                PMV_RUN, PMV_WAIT_WFI, PMV_WAIT_WFE, PMV_WAKE:
                    main_q <= 1'b1; // see [RULE_01]
                PMV_ACT_HALT:
                    main_q <= !link.ah_ulp_sel; // see [RULE_16] [RULE_21]
                default: main_q <= 1'b0; // see [RULE_02]
            endcase
        end
    end

    // Interrupt request and ignored-halt pulse
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            ign_q <= 1'b0;
        end else begin
            irq_q <= flag_q && irq_en_q; // see [RULE_06]
            ign_q <= (state_q == PMV_RUN) && link.halt_req &&
                link.periph_pending; // see [RULE_18]
        end
    end

    assign link.reg_rdata = rdata_q;
    assign link.mode = state_q;
    assign link.cpu_clk_en = cpu_q;
    assign link.periph_clk_en = per_q;
    assign link.osc_en = osc_q;
    assign link.main_reg = main_q;
    assign link.det_irq = irq_q;
    assign link.halt_ignored = ign_q;
    assign det_on = det_en_q;
    assign det_level = lvl_q;
    assign ref_on = ref_on_q;
    assign main_reg = main_q;
endmodule // pmv_dev
`default_nettype wire

// >>> rtl/pmv_host.sv
// Core-side end: Avalon-MM slave issuing instructions to the power unit
`timescale 1ns/1ps
`default_nettype none
module pmv_host (
    input wire logic mclk,
    input wire logic rst_n,
    pmv_if.host link,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic any_irq,
    input wire logic wake_event,
    input wire logic ext_irq,
    input wire logic rtc_irq,
    input wire logic periph_pending
);
    import pmv_pkg::*;

    typedef enum logic [1:0] {
        PMV_P_IDLE = 2'h0,
        PMV_P_DEV = 2'h1,
        PMV_P_CAP = 2'h2,
        PMV_P_DONE = 2'h3
    } pmv_phase_type;

    pmv_phase_type ph_q;
    logic wait_q, rd_q, wr_q, ign_q, rtc_on_q, ahs_q;
    logic [31:0] rdat_q;
    logic [7:0] addr_q, wdat_q;
    logic [4:0] cmd_q;
    logic [4:0] wake_q;
    logic go, is_dev, is_cmd, is_cfg, is_stat;

    assign go = (avs_read || avs_write) && ph_q == PMV_P_IDLE;
    assign is_dev = (avs_address & 8'hf8) == PMV_H_DEV;
    assign is_cmd = avs_address == PMV_H_CMD;
    assign is_cfg = avs_address == PMV_H_CFG;
    assign is_stat = avs_address == PMV_H_STAT;

    // ==========================================================
    // Bus sequencing: local access answers after 1 cycle, device after 3
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ph_q <= PMV_P_IDLE;
            wait_q <= 1'b1;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 8'h00;
            wdat_q <= 8'h00;
            rdat_q <= 32'h0000_0000;
        end else begin
            case (ph_q)
                PMV_P_IDLE: begin
                    if (go && is_dev) begin
                        rd_q <= avs_read;
                        wr_q <= avs_write;
                        addr_q <= {6'h00, avs_address[3:2]};
                        wdat_q <= avs_writedata[7:0];
                        ph_q <= PMV_P_DEV;
                    end else if (go) begin
                        rdat_q <= is_cfg ? {30'h0, ahs_q, rtc_on_q} :
                            is_stat ? {24'h0, 3'h0, ign_q,
                            link.main_reg, link.mode} : 32'h0000_0000;
                        wait_q <= 1'b0;
                        ph_q <= PMV_P_DONE;
                    end
                end
                PMV_P_DEV: begin
                    rd_q <= 1'b0;
                    wr_q <= 1'b0;
                    ph_q <= PMV_P_CAP;
                end
                PMV_P_CAP: begin
                    rdat_q <= {24'h0, link.reg_rdata};
                    wait_q <= 1'b0;
                    ph_q <= PMV_P_DONE;
                end
                PMV_P_DONE: begin
                    wait_q <= 1'b1;
                    ph_q <= PMV_P_IDLE;
                end
                default: ph_q <= PMV_P_IDLE;
            endcase
        end
    end

    // Instruction pulses last one cycle; several bits issue together
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cmd_q <= 5'h00;
        end else if (go && avs_write && is_cmd) begin
            cmd_q <= avs_writedata[4:0];
        end else begin
            cmd_q <= 5'h00;
        end
    end

    // Clock-controller settings
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rtc_on_q <= 1'b0;
            ahs_q <= 1'b0;
        end else if (go && avs_write && is_cfg) begin
            rtc_on_q <= avs_writedata[0];
            ahs_q <= avs_writedata[1]; // see [RULE_21]
        end
    end

    // Sticky ignored-halt; a new report beats a write-one clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ign_q <= 1'b0;
        end else if (link.halt_ignored) begin
            ign_q <= 1'b1; // see [RULE_18]
        end else if (go && avs_write && is_stat &&
                avs_writedata[PMV_S_IGN]) begin
            ign_q <= 1'b0;
        end
    end

    // Wake sources registered so the link sees flop outputs only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wake_q <= 5'h00;
        end else begin
            wake_q <= {any_irq, wake_event, ext_irq, rtc_irq,
                periph_pending};
        end
    end

    assign avs_readdata = rdat_q;
    assign avs_waitrequest = wait_q;
    assign link.reg_addr = addr_q;
    assign link.reg_rd = rd_q;
    assign link.reg_wr = wr_q;
    assign link.reg_wdata = wdat_q;
    assign link.wfi_req = cmd_q[PMV_C_WFI];
    assign link.wfe_req = cmd_q[PMV_C_WFE];
    assign link.halt_req = cmd_q[PMV_C_HALT];
    assign link.lprun_enter = cmd_q[PMV_C_LPIN]; // see [RULE_14]
    assign link.lprun_exit = cmd_q[PMV_C_LPOUT]; // see [RULE_14]
    assign link.any_irq = wake_q[4];
    assign link.wake_event = wake_q[3];
    assign link.ext_irq = wake_q[2];
    assign link.rtc_irq = wake_q[1];
    assign link.periph_pending = wake_q[0];
    assign link.rtc_clk_on = rtc_on_q;
    assign link.ah_ulp_sel = ahs_q;
endmodule // pmv_host
`default_nettype wire

// >>> bench/pmv_asserts.sv
// Concurrent checks on the link between the two power-unit ends
`timescale 1ns/1ps
`default_nettype none
module pmv_asserts (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic any_irq,
    input wire logic wake_event,
    input wire logic ext_irq,
    input wire logic periph_pending,
    input wire logic halt_req,
    input wire pmv_pkg::pmv_mode_type mode,
    input wire logic cpu_clk_en,
    input wire logic main_reg,
    input wire logic halt_ignored
);
    import pmv_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Regulator and clock gating follow the mode
    chk_run_main: assert property (
        mode inside {PMV_RUN, PMV_WAIT_WFI, PMV_WAIT_WFE} |-> main_reg)
        else $error("main regulator off in run or wait");
    chk_lp_ulp: assert property (
        mode inside {PMV_LP_RUN, PMV_LP_WAIT, PMV_HALT} |-> !main_reg)
        else $error("main regulator on in low power mode");
    chk_sleep_clk: assert property (
        mode inside {PMV_WAIT_WFI, PMV_WAIT_WFE, PMV_LP_WAIT, PMV_HALT,
        PMV_ACT_HALT} |-> !cpu_clk_en) else $error("cpu clock running");
    // ==========================================================
    // Mode sequencing; reset release must find the core in run
    chk_reset_run: assert property (
        $rose(rst_n) |-> mode == PMV_RUN) else $error("not in run");
    chk_wait_hold: assert property (
        mode == PMV_WAIT_WFI && !any_irq |=> mode == PMV_WAIT_WFI)
        else $error("wait left without interrupt");
    chk_halt_refused: assert property (
        mode == PMV_RUN && halt_req && periph_pending
        |=> halt_ignored && mode == PMV_RUN) else $error("halt taken");
    chk_lpwait_evt: assert property (
        mode == PMV_LP_WAIT && wake_event |=> mode == PMV_LP_RUN)
        else $error("event did not resume low power run");
    chk_halt_wake: assert property (
        mode == PMV_HALT && ext_irq |=> mode == PMV_WAKE)
        else $error("external interrupt did not wake halt");
    cover property (mode == PMV_HALT);
    cover property (halt_ignored);
    cover property (mode == PMV_LP_WAIT);
endmodule // pmv_asserts
`default_nettype wire

// >>> bench/power_mode_and_voltage_detect_tb_top.sv
// Testbench joining host end and power unit through the link
`timescale 1ns/1ps
`default_nettype none
module power_mode_and_voltage_detect_tb_top;
    import pmv_pkg::*;
    logic mclk, rst_n, sup_below, ext_below, avs_read, avs_write;
    logic any_irq, wake_event, ext_irq, rtc_irq, periph_pending;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic avs_waitrequest, det_on, ref_on, main_reg;
    logic [2:0] det_level;
    int n_mismatch = 0;
    int checks = 0;
    pmv_if pmv_if_inst ();
    // Short counts keep reference start and fast wake quick
    pmv_dev #(.REF_START_CYCLES(20), .FAST_WAKE_CYCLES(5)) pmv_dev_inst (
        .mclk(mclk), .rst_n(rst_n), .link(pmv_if_inst),
        .supply_below_raw(sup_below), .ext_below_raw(ext_below),
        .det_on(det_on), .det_level(det_level), .ref_on(ref_on),
        .main_reg(main_reg));
    pmv_host pmv_host_inst (.mclk(mclk), .rst_n(rst_n), .link(pmv_if_inst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .any_irq(any_irq), .wake_event(wake_event), .ext_irq(ext_irq),
        .rtc_irq(rtc_irq), .periph_pending(periph_pending));
    pmv_asserts pmv_asserts_inst (.mclk(mclk), .rst_n(rst_n),
        .any_irq(pmv_if_inst.any_irq), .wake_event(pmv_if_inst.wake_event),
        .ext_irq(pmv_if_inst.ext_irq), .halt_req(pmv_if_inst.halt_req),
        .periph_pending(pmv_if_inst.periph_pending),
        .mode(pmv_if_inst.mode), .cpu_clk_en(pmv_if_inst.cpu_clk_en),
        .main_reg(pmv_if_inst.main_reg),
        .halt_ignored(pmv_if_inst.halt_ignored));
    // ==========================================================
    // Clock, reporting and bus helpers
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic report_and_stop();
        $display("mismatches=%0d checks=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is seen low; bounded so a hang ends
    task automatic bus(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        int i;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (i == 20) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Polls status: wake latency is the designer's, so no cycle count
    task automatic wmode(input logic [3:0] exp);
        for (int k = 0; k < 60 && rd[3:0] !== exp; k++)
            bus(1'b0, PMV_H_STAT, 32'h0);
        chk({28'h0, rd[3:0]}, {28'h0, exp});
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_det();
        rdchk(PMV_H_DEV + 8'h4, 32'h0);
        rdchk(8'h40, 32'h0); // unmapped place reads zero
        bus(1'b1, PMV_H_DEV, 32'h1f);
        ext_below <= 1'b1;
        repeat (8) @(posedge mclk);
        rdchk(PMV_H_DEV, 32'h7f);
        chk({31'h0, pmv_if_inst.det_irq}, 32'h1);
        bus(1'b1, PMV_H_DEV, 32'h1f);
        rdchk(PMV_H_DEV, 32'h7f);
        bus(1'b1, PMV_H_DEV, 32'h2f);
        rdchk(PMV_H_DEV, 32'h4f);
        chk({31'h0, pmv_if_inst.det_irq}, 32'h0);
        chk({28'h0, det_on, det_level}, 32'hf);
        ext_below <= 1'b0;
        repeat (8) @(posedge mclk);
        rdchk(PMV_H_DEV, 32'h2f);
        bus(1'b1, PMV_H_DEV, 32'h2d);
        sup_below <= 1'b1;
        repeat (8) @(posedge mclk);
        rdchk(PMV_H_DEV, 32'h6d);
        rdchk(PMV_H_DEV + 8'h4, 32'h1);
        bus(1'b1, PMV_H_DEV + 8'h4, 32'h2);
        rdchk(PMV_H_DEV + 8'h4, 32'h3);
    endtask
    task automatic t_modes();
        bus(1'b1, PMV_H_CMD, 32'h1);
        wmode(4'h9);
        any_irq <= 1'b1;
        wmode(4'h8);
        any_irq <= 1'b0;
        periph_pending <= 1'b1;
        bus(1'b1, PMV_H_CMD, 32'h4);
        rdchk(PMV_H_STAT, 32'h18);
        periph_pending <= 1'b0;
        bus(1'b1, PMV_H_STAT, 32'h10);
        bus(1'b1, PMV_H_CMD, 32'h4);
        wmode(4'h6);
        ext_irq <= 1'b1;
        wmode(4'h8);
        ext_irq <= 1'b0;
        bus(1'b1, PMV_H_DEV + 8'h4, 32'h6);
        bus(1'b1, PMV_H_CFG, 32'h1);
        bus(1'b1, PMV_H_CMD, 32'h4);
        wmode(4'hd);
        rtc_irq <= 1'b1;
        wmode(4'h8);
        rtc_irq <= 1'b0;
        bus(1'b1, PMV_H_CMD, 32'h8);
        any_irq <= 1'b1;
        repeat (6) @(posedge mclk);
        wmode(4'h3);
        any_irq <= 1'b0;
        bus(1'b1, PMV_H_CMD, 32'h2);
        wmode(4'h4);
        wake_event <= 1'b1;
        wmode(4'h3);
        wake_event <= 1'b0;
        bus(1'b1, PMV_H_CMD, 32'h10);
        wmode(4'h8);
        bus(1'b1, PMV_H_CMD, 32'h2);
        wmode(4'ha);
        wake_event <= 1'b1;
        wmode(4'h8);
    endtask
    initial begin
        {rst_n, sup_below, ext_below, avs_read, avs_write} = 5'h0;
        {any_irq, wake_event, ext_irq, rtc_irq, periph_pending} = 5'h0;
        avs_address = 8'h0;
        avs_writedata = 32'h0;
        rd = 32'h0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_det();
        t_modes();
        report_and_stop();
    end
endmodule // power_mode_and_voltage_detect_tb_top
`default_nettype wire
